// ===== include/anpt_pkg.sv
// Package for the next page transmit register block
package anpt_pkg;
   // ***************************************
   // Register map and field layout
   // ***************************************
   localparam logic [4:0] ADDR_NP_TX_WORD = 5'h07;
   localparam logic [4:0] ADDR_NP_STATUS = 5'h1e;
   localparam int BIT_MORE_PAGES = 15;
   localparam int BIT_RESERVED = 14;
   localparam int BIT_MSG_PAGE = 13;
   localparam int BIT_COMPLY_ACK = 12;
   localparam int BIT_TOGGLE = 11;
   localparam int CODE_MSB = 10;
   localparam int CODE_W = 11;
   // ***************************************
   // Reset values
   // ***************************************
   localparam logic RST_MORE_PAGES = 1'b0;
   localparam logic RST_MSG_PAGE = 1'b1;
   localparam logic RST_COMPLY_ACK = 1'b0;
   localparam logic RST_TOGGLE = 1'b0;
   localparam logic [10:0] RST_CODE = 11'h001;
   localparam logic [15:0] RD_UNMAPPED = 16'h0000;

   // Page contents as seen by the arbitration logic
   typedef struct packed {
      logic more_pages_flag;
      logic message_page_select;
      logic comply_acknowledge;
      logic tx_toggle_bit;
      logic [10:0] code;
   } anpt_page_s;

   // Pack a page into its 16-bit register image, reserved bit zero
   function automatic logic [15:0] anpt_pack(input anpt_page_s p);
      anpt_pack = {p.more_pages_flag, 1'b0, p.message_page_select,
         p.comply_acknowledge, p.tx_toggle_bit, p.code};
   endfunction
endpackage

// ===== logic/anpt_reg.sv
// Next page transmit register with toggle tracking
//
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
module anpt_reg (
   mclk,
   arst_n,
   reg_addr,
   reg_wdata,
   reg_wr,
   reg_rd,
   reg_rdata,
   page_sent,
   tx_page,
   page_exchanged_q
);
   input wire logic mclk;
   input wire logic arst_n;
   input wire logic [4:0] reg_addr;
   input wire logic [15:0] reg_wdata;
   input wire logic reg_wr;
   input wire logic reg_rd;
   output logic [15:0] reg_rdata;
   input wire logic page_sent;
   output anpt_pkg::anpt_page_s tx_page;
   output logic page_exchanged_q;

   // ***************************************
   // Storage
   // ***************************************
   logic more_pages_q;
   logic msg_page_q;
   logic comply_ack_q;
   logic toggle_q;
   logic [10:0] code_q;
   logic [15:0] rdata_q;
   logic sent_sync;
   logic sent_prev_q;
   logic exch_q;
   logic sent_edge;
   anpt_pkg::anpt_page_s page_q;
   anpt_pkg::anpt_page_s cur_page;
   logic wr_word;
   logic rd_status;

   // Strobe qualified by one register address
   function automatic logic reg_hit(input logic stb, input logic [4:0] a,
      input logic [4:0] target);
      reg_hit = stb && (a == target);
   endfunction

   // Shared decode so every writable field sees the same write qualifier
   assign wr_word = reg_hit(reg_wr, reg_addr, anpt_pkg::ADDR_NP_TX_WORD);
   assign rd_status = reg_hit(reg_rd, reg_addr, anpt_pkg::ADDR_NP_STATUS);

   // Exchange indication comes from the arbitration side as a pin level
   anpt_sync u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .din(page_sent),
      .dout(sent_sync)
   );

   // Rising edge of the resolved exchange level marks one exchanged word
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sent_prev_q <= 1'b0;
      end else begin
         sent_prev_q <= sent_sync;
      end
   end
   assign sent_edge = sent_sync & ~sent_prev_q;

   // ***************************************
   // Software-writable fields
   // ***************************************
   // more pages write
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         more_pages_q <= anpt_pkg::RST_MORE_PAGES;
      end else if (wr_word) begin
         more_pages_q <= reg_wdata[anpt_pkg::BIT_MORE_PAGES];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         msg_page_q <= anpt_pkg::RST_MSG_PAGE;
      end else if (wr_word) begin
         msg_page_q <= reg_wdata[anpt_pkg::BIT_MSG_PAGE];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         comply_ack_q <= anpt_pkg::RST_COMPLY_ACK;
      end else if (wr_word) begin
         comply_ack_q <= reg_wdata[anpt_pkg::BIT_COMPLY_ACK];
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         code_q <= anpt_pkg::RST_CODE;
      end else if (wr_word) begin
         code_q <= reg_wdata[anpt_pkg::CODE_MSB:0];
      end
   end

   // ***************************************
   // Toggle tracking
   // ***************************************
   // invert per exchange
   // Software writes never reach this bit, so it cannot desync arbitration
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         toggle_q <= anpt_pkg::RST_TOGGLE;
      end else if (sent_edge) begin
         toggle_q <= ~toggle_q;
      end
   end

   // Sticky exchange flag; a new exchange wins over the read clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         exch_q <= 1'b0;
      end else if (sent_edge) begin
         exch_q <= 1'b1;
      end else if (rd_status) begin
         exch_q <= 1'b0;
      end
   end

   // ***************************************
   // Page output and readback
   // ***************************************
   always_comb begin
      cur_page.more_pages_flag = more_pages_q;
      cur_page.message_page_select = msg_page_q;
      cur_page.comply_acknowledge = comply_ack_q;
      cur_page.tx_toggle_bit = toggle_q;
      cur_page.code = code_q;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         page_q <= '{anpt_pkg::RST_MORE_PAGES, anpt_pkg::RST_MSG_PAGE,
            anpt_pkg::RST_COMPLY_ACK, anpt_pkg::RST_TOGGLE, anpt_pkg::RST_CODE};
      end else begin
         page_q <= cur_page;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= anpt_pkg::RD_UNMAPPED;
      end else if (reg_rd) begin
         case (reg_addr)
            anpt_pkg::ADDR_NP_TX_WORD: rdata_q <= anpt_pkg::anpt_pack(cur_page);
            anpt_pkg::ADDR_NP_STATUS: rdata_q <= {15'h0000, exch_q};
            default: rdata_q <= anpt_pkg::RD_UNMAPPED;
         endcase
      end else begin
         rdata_q <= anpt_pkg::RD_UNMAPPED; // Data valid only the cycle after
      end
   end

   assign reg_rdata = rdata_q;
   assign tx_page = page_q;
   assign page_exchanged_q = exch_q;
endmodule

// ===== logic/anpt_sync.sv
// Three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module anpt_sync (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic din,
   output logic dout
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic out_q;

   // Shift chain; only the second stage reads the first
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Accept a change only once two late stages agree
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         out_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         out_q <= s3_q;
      end
   end

   assign dout = out_q;
endmodule

// ===== tb/anpt_chk.sv
// Port checker for the next page transmit register
`timescale 1ns/1ps
module anpt_chk (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic page_sent,
   input wire anpt_pkg::anpt_page_s tx_page,
   input wire logic page_exchanged_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   rd_image_a: assert property (reg_rd && reg_addr == 5'h07
      |=> reg_rdata == {tx_page[14], 1'b0, tx_page[13:0]}) else $error("read image wrong");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not idle");
   resv_zero_a: assert property (reg_rdata[14] == 1'b0) else $error("reserved set");
   flags_follow_a: assert property (reg_wr && reg_addr == 5'h07
      |-> ##2 tx_page[14:12] == {$past(reg_wdata[15], 2), $past(reg_wdata[13:12], 2)})
      else $error("flags not loaded");
   code_follow_a: assert property (reg_wr && reg_addr == 5'h07
      |-> ##2 tx_page[10:0] == $past(reg_wdata[10:0], 2)) else $error("code not loaded");
   tog_flip_a: assert property ($rose(page_sent) |-> ##[3:7] $changed(tx_page[11]))
      else $error("toggle did not flip");
   tog_hold_a: assert property (!page_sent [*8] |=> $stable(tx_page[11]))
      else $error("toggle moved");
   unmap_zero_a: assert property (reg_rd && reg_addr != 5'h07 && reg_addr != 5'h1e
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
endmodule
bind anpt_reg anpt_chk anpt_chk_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .page_sent(page_sent), .tx_page(tx_page), .page_exchanged_q(page_exchanged_q));

// ===== tb/anpt_lp.sv
// Link partner model that takes one next page per request
`timescale 1ns/1ps
module anpt_lp (
   input wire logic mclk,
   input wire logic go,
   input wire anpt_pkg::anpt_page_s tx_page,
   output logic page_sent,
   output anpt_pkg::anpt_page_s got
);
   initial page_sent = 1'b0;
   always @(posedge mclk) begin
      if (go) begin
         got <= tx_page;
         page_sent <= 1'b1;
         repeat (3) @(posedge mclk);
         page_sent <= 1'b0; // Short level, one edge per page
      end
   end
endmodule

// ===== tb/anpt_reg_bench.sv
// Self-checking bench for the next page transmit register
`timescale 1ns/1ps
module anpt_reg_bench;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] reg_addr = 5'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic go = 1'b0;
   logic rd_q = 1'b0;
   logic page_sent, page_exchanged_q;
   logic [15:0] reg_rdata;
   anpt_pkg::anpt_page_s tx_page, got;
   logic [15:0] shadow = 16'h2001;
   logic [15:0] q[$];
   logic [31:0] seed = 32'd66310;
   int mismatches = 0, n_tests = 0, cyc = 0;
   always #50 mclk = ~mclk;
   anpt_reg anpt_reg_i (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .page_sent(page_sent), .tx_page(tx_page), .page_exchanged_q(page_exchanged_q));
   anpt_lp anpt_lp_i (.mclk(mclk), .go(go), .tx_page(tx_page), .page_sent(page_sent), .got(got));
   // ****
   // Helpers
   // ****
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      xs = x ^ (x << 5);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // One bus cycle per call, so strobes never get two writes in one step
   task automatic op(input logic w, r, input logic [4:0] a, input logic [15:0] d, e);
      @(posedge mclk);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      if (r) q.push_back(e);
   endtask
   task report_and_stop;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Read data stand one cycle after the strobe
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rd_q) check(reg_rdata, q.pop_front());
      rd_q <= reg_rd;
      if (cyc == 1000) begin
         mismatches++;
         report_and_stop;
      end
   end
   initial begin
      repeat (5) @(posedge mclk);
      check({tx_page[14], 1'b0, tx_page[13:0]}, 16'h2001);
      arst_n <= 1'b1;
      op(0, 1, 5'h07, 0, 16'h2001);
      for (int i = 0; i < 12; i++) begin
         seed = xs(seed);
         op(1, 0, 5'h07, seed[15:0], 0);
         shadow = seed[15:0] & 16'hb7ff | shadow & 16'h0800;
         op(0, 1, 5'h07, 0, shadow);
         op(1, 0, {seed[20:17], 1'b0}, ~seed[15:0], 0);
         op(0, 1, {seed[20:17], 1'b0}, 0, 16'h0000);
      end
      for (int i = 0; i < 3; i++) begin
         op(0, 0, 0, 0, 0);
         go <= 1'b1;
         @(posedge mclk);
         go <= 1'b0;
         repeat (12) @(posedge mclk);
         check({got[14], 1'b0, got[13:0]}, shadow);
         check({15'h0000, page_exchanged_q}, 16'h0001);
         shadow[11] = ~shadow[11];
         op(0, 1, 5'h07, 0, shadow);
         op(0, 1, 5'h1e, 0, 16'h0001);
         op(0, 1, 5'h1e, 0, 16'h0000);
         op(0, 0, 0, 0, 0);
         check({15'h0000, page_exchanged_q}, 16'h0000);
      end
      op(0, 0, 0, 0, 0);
      repeat (3) @(posedge mclk);
      report_and_stop;
   end
endmodule
